// *** hw/sdc_core.sv ***
// SDRAM controller: flat memory agent port to SDR SDRAM command sequences
//
// Contract
// RULE1: Data width 8, 16, 32 or 64 bits
// RULE2: Several chip selects form one space
// RULE3: Flat memory only, no software registers
// RULE4: Wait states stall reads and writes
// RULE5: Pipelined variable-latency reads with valid flag
// RULE6: Refresh periodically interrupts data transfers
// RULE7: SDRAM clock same frequency, maybe shifted
// RULE8: Clock enable always high, no power-down
// RULE9: Optional sharing of addr, dq, dqm pins
// RULE10: Bridge byte address wired in full
// RULE11: One open row; hits skip activate/precharge
// RULE12: Keep bridge during same-row back-to-back traffic
// RULE13: Precharge when traffic stops or refresh due
// RULE14: All options fixed by parameters
// RULE15: Read data after CAS latency 1-3
// RULE16: Init issues 1-8 refreshes, default 2
// RULE17: One refresh every 15.625 us
// RULE18: Wait 100 us before initialization
// RULE19: Stall requests during init and refresh; a refresh raises no wait, so one request can still enter the holding slot
// RULE20: Address splits into chip, bank, row, column
`timescale 1ns/1ns
module sdc_core import sdc_pkg::*; #(
  parameter int DQ_W = 32,        // 8, 16, 32 or 64; see RULE1
  parameter int NUM_CS = 1,       // 1, 2, 4 or 8; see RULE2
  parameter int NUM_BANKS = 4,    // 2 or 4
  parameter int ROW_BITS = 12,
  parameter int COL_BITS = 8,
  parameter int CAS_LAT = 3,      // 1, 2 or 3
  parameter int INIT_REFS = 2,    // 1 to 8
  parameter bit SHARE_PINS = 1'b0, // Fixed at build time, never at run time; see RULE14
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int REFI_CYCLES = REFI_CYC,
  localparam int BE_W = DQ_W / 8,
  localparam int BA_W = $clog2(NUM_BANKS),
  localparam int CS_B = $clog2(NUM_CS),
  localparam int CS_W = (CS_B > 0) ? CS_B : 1,
  localparam int AW = CS_B + BA_W + ROW_BITS + COL_BITS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [AW-1:0] hostAddr,
  input wire logic hostRead,
  input wire logic hostWrite,
  input wire logic [DQ_W-1:0] hostWrData,
  input wire logic [BE_W-1:0] hostByteEn,
  output logic hostWait,
  output logic [DQ_W-1:0] hostRdData,
  output logic hostRdValid,
  output logic sdCke,
  output logic [NUM_CS-1:0] sdCsN,
  output logic sdRasN,
  output logic sdCasN,
  output logic sdWeN,
  output logic [BA_W-1:0] sdBa,
  output logic [ROW_BITS-1:0] sdAddr,
  output logic [BE_W-1:0] sdDqm,
  output logic sdBusOe,
  output logic [DQ_W-1:0] sdDqOut,
  output logic sdDqOe,
  input wire logic [DQ_W-1:0] sdDqIn,
  output logic bridgeReq,
  input wire logic bridgeGrant
);
  // ==========================================================
  // Types and state
  typedef enum logic [3:0] {
    S_INIT_WAIT, S_INIT_PRE, S_INIT_REF, S_INIT_MRS, S_IDLE, S_ACT, S_OPEN, S_PRE, S_REF
  } sdc_state_t;

  sdc_state_t stateFf;
  logic [3:0] dlyFf;                    // Command spacing countdown
  logic [1:0] wrRecFf;                  // Write recovery countdown
  logic [3:0] initRefFf;                // Refreshes done during init
  logic readyFf;                        // Initialization complete
  logic openFf;                         // A row is open
  logic [ROW_BITS-1:0] openRowFf;
  logic [BA_W-1:0] openBankFf;
  logic [CS_W-1:0] openCsFf;
  logic pendFf;                         // One held request
  logic pendWrFf;
  logic [AW-1:0] pendAddrFf;
  logic [DQ_W-1:0] pendDataFf;
  logic [BE_W-1:0] pendBeFf;
  logic waitFf;
  logic [2:0] cmdFf;
  logic [NUM_CS-1:0] csNFf;
  logic [BA_W-1:0] baFf;
  logic [ROW_BITS-1:0] addrFf;
  logic [BE_W-1:0] dqmFf;
  logic [DQ_W-1:0] dqOutFf;
  logic dqOeFf;
  logic busOeFf;
  logic bridgeReqFf;
  logic [CAS_LAT+2:0] rdPipeFf;         // Read command age tracker
  logic [DQ_W-1:0] dqSyncAFf;
  logic [DQ_W-1:0] dqSyncBFf;
  logic [DQ_W-1:0] rdDataFf;
  logic rdValidFf;

  sdc_tmr_if tmr ();

  sdc_timer #(.INIT_CYCLES(INIT_CYCLES), .REFI_CYCLES(REFI_CYCLES)) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .tmr(tmr)
  );

  // ==========================================================
  // Address decode, flat word address = {chip, bank, row, col}; see RULE3
  function automatic logic [ROW_BITS-1:0] f_col(input logic [AW-1:0] a);
    return ROW_BITS'(a[COL_BITS-1:0]); // see RULE20
  endfunction
  function automatic logic [ROW_BITS-1:0] f_row(input logic [AW-1:0] a);
    return a[COL_BITS +: ROW_BITS];
  endfunction
  function automatic logic [BA_W-1:0] f_bank(input logic [AW-1:0] a);
    return a[COL_BITS+ROW_BITS +: BA_W];
  endfunction
  function automatic logic [CS_W-1:0] f_cs(input logic [AW-1:0] a);
    logic [AW-1:0] t;
    t = a >> (COL_BITS + ROW_BITS + BA_W);
    return t[CS_W-1:0];
  endfunction
  // One chip selected, active low
  function automatic logic [NUM_CS-1:0] f_sel(input logic [CS_W-1:0] c);
    return ~(NUM_CS'(1) << c); // see RULE2
  endfunction
  // Same chip, bank and row as the open one
  function automatic logic f_hit(input logic [AW-1:0] a);
    return openFf && f_row(a) == openRowFf && f_bank(a) == openBankFf && f_cs(a) == openCsFf;
  endfunction
  function automatic logic [3:0] f_ld(input int n);
    return 4'(n - 1);
  endfunction

  // ==========================================================
  // Request acceptance and issue decisions
  logic take;       // Host request taken this cycle
  logic own;        // Pins are ours to drive
  logic dlyDone;
  logic wrBlock;    // Write would collide with read data on dq
  logic consume;    // Held request issued as a column command
  logic chain;      // Next request can follow back to back
  logic nxt_wait;
  logic nxt_bridgeReq; // Bridge request for the next cycle

  always_comb begin
    take = (hostRead || hostWrite) && !waitFf;
    own = !SHARE_PINS || (bridgeReqFf && bridgeGrant); // see RULE9
    dlyDone = (dlyFf == 4'h0);
    wrBlock = pendWrFf && (|rdPipeFf[CAS_LAT+1:0]);
    // Open row hit needs no activate or precharge
    consume = stateFf == S_OPEN && dlyDone && pendFf && f_hit(pendAddrFf) && !wrBlock
      && own; // see RULE11
    // Streaming continues only for same-row, same-direction traffic
    chain = consume && take && f_hit(hostAddr) && (hostWrite == pendWrFf) && !tmr.refDue;
    // Stall until the single holding slot is free; see RULE4
    nxt_wait = !readyFf || !(!(take || (pendFf && !consume)) || chain); // see RULE19
    // Bridge wanted unless idle with nothing owed or still waiting out the settle delay; see RULE12
    nxt_bridgeReq = SHARE_PINS && !(stateFf == S_INIT_WAIT && !tmr.initDone)
      && !(stateFf == S_IDLE && !pendFf && !tmr.refDue);
  end

  assign tmr.refAck = stateFf == S_IDLE && tmr.refDue && own;

  // Holding slot for one request and the wait flag
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pendFf <= 1'b0;
      pendWrFf <= 1'b0;
      pendAddrFf <= '0;
      pendDataFf <= '0;
      pendBeFf <= '0;
      waitFf <= 1'b1;
    end else begin
      waitFf <= nxt_wait; // see RULE4
      if (take) begin
        pendFf <= 1'b1;
        pendWrFf <= hostWrite;
        pendAddrFf <= hostAddr;
        pendDataFf <= hostWrData;
        pendBeFf <= hostByteEn;
      end else if (consume) begin
        pendFf <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Command sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stateFf <= S_INIT_WAIT;
      dlyFf <= 4'h0;
      wrRecFf <= 2'h0;
      initRefFf <= 4'h0;
      readyFf <= 1'b0;
      openFf <= 1'b0;
      openRowFf <= '0;
      openBankFf <= '0;
      openCsFf <= '0;
      cmdFf <= CMD_NOP;
      csNFf <= '1;
      baFf <= '0;
      addrFf <= '0;
      dqmFf <= '0;
      dqOutFf <= '0;
      dqOeFf <= 1'b0;
    end else begin
      // Defaults: no operation, dq released
      cmdFf <= CMD_NOP;
      csNFf <= '1;
      dqOeFf <= 1'b0;
      dqmFf <= '0;
      if (!dlyDone) begin
        dlyFf <= dlyFf - 4'h1;
      end
      if (wrRecFf != 2'h0) begin
        wrRecFf <= wrRecFf - 2'h1;
      end
      unique case (stateFf)
        S_INIT_WAIT: begin
          // Nothing reaches the pins until the settle delay ends
          if (tmr.initDone && own) begin // see RULE18
            cmdFf <= CMD_PRE;
            csNFf <= '0;
            addrFf <= ROW_BITS'(1) << AP_BIT;
            dlyFf <= f_ld(RP_CYC);
            stateFf <= S_INIT_PRE;
          end
        end
        S_INIT_PRE, S_INIT_REF: begin
          if (dlyDone) begin
            if (initRefFf < 4'(INIT_REFS)) begin
              cmdFf <= CMD_REF; // see RULE16
              csNFf <= '0;
              initRefFf <= initRefFf + 4'h1;
              dlyFf <= f_ld(RFC_CYC);
              stateFf <= S_INIT_REF;
            end else begin
              // Burst length one, sequential, chosen CAS latency
              cmdFf <= CMD_MRS;
              csNFf <= '0;
              baFf <= '0;
              addrFf <= ROW_BITS'(CAS_LAT) << MODE_CAS_LSB; // see RULE15
              dlyFf <= f_ld(MRD_CYC);
              stateFf <= S_INIT_MRS;
            end
          end
        end
        S_INIT_MRS: begin
          if (dlyDone) begin
            readyFf <= 1'b1;
            stateFf <= S_IDLE;
          end
        end
        S_IDLE: begin
          // Refresh takes priority over a waiting request
          if (tmr.refDue && own) begin
            cmdFf <= CMD_REF; // see RULE6
            csNFf <= '0;
            dlyFf <= f_ld(RFC_CYC);
            stateFf <= S_REF;
          end else if (pendFf && own) begin
            cmdFf <= CMD_ACT;
            csNFf <= f_sel(f_cs(pendAddrFf));
            baFf <= f_bank(pendAddrFf);
            addrFf <= f_row(pendAddrFf);
            openFf <= 1'b1;
            openRowFf <= f_row(pendAddrFf);
            openBankFf <= f_bank(pendAddrFf);
            openCsFf <= f_cs(pendAddrFf);
            dlyFf <= f_ld(RCD_CYC);
            stateFf <= S_ACT;
          end
        end
        S_ACT: begin
          if (dlyDone) begin
            stateFf <= S_OPEN;
          end
        end
        S_OPEN: begin
          if (consume) begin
            cmdFf <= pendWrFf ? CMD_WR : CMD_RD;
            csNFf <= f_sel(openCsFf);
            baFf <= openBankFf;
            addrFf <= f_col(pendAddrFf);
            if (pendWrFf) begin
              dqOutFf <= pendDataFf;
              dqOeFf <= 1'b1;
              dqmFf <= ~pendBeFf;
              wrRecFf <= 2'(WR_CYC - 1);
            end
          end else if (dlyDone && wrRecFf == 2'h0 && (tmr.refDue
              || (pendFf && !f_hit(pendAddrFf)) || (!pendFf && !hostRead && !hostWrite))) begin
            // Closing the row bounds row-active time and frees the bridge
            cmdFf <= CMD_PRE; // see RULE13
            csNFf <= f_sel(openCsFf);
            addrFf <= ROW_BITS'(1) << AP_BIT;
            openFf <= 1'b0;
            dlyFf <= f_ld(RP_CYC);
            stateFf <= S_PRE;
          end
        end
        S_PRE, S_REF: begin
          if (dlyDone) begin
            stateFf <= S_IDLE;
          end
        end
        default: stateFf <= S_INIT_WAIT;
      endcase
    end
  end

  // ==========================================================
  // Bridge ownership: requested before activate, held through precharge until back in idle with nothing owed
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bridgeReqFf <= 1'b0;
      busOeFf <= !SHARE_PINS;
    end else begin
      bridgeReqFf <= nxt_bridgeReq; // see RULE12
      // Pins let go at the same edge as the request, so they never outlive the grant
      busOeFf <= !SHARE_PINS || (nxt_bridgeReq && bridgeReqFf && bridgeGrant); // see RULE9
    end
  end

  // ==========================================================
  // Read return: two sync flops on dq, then the output register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdPipeFf <= '0;
      dqSyncAFf <= '0;
      dqSyncBFf <= '0;
      rdDataFf <= '0;
      rdValidFf <= 1'b0;
    end else begin
      rdPipeFf <= {rdPipeFf[CAS_LAT+1:0], consume && !pendWrFf};
      dqSyncAFf <= sdDqIn;
      dqSyncBFf <= dqSyncAFf;
      // Valid marks each returned word; latency grows with CAS latency
      rdValidFf <= rdPipeFf[CAS_LAT+2]; // see RULE5
      if (rdPipeFf[CAS_LAT+2]) begin
        rdDataFf <= dqSyncBFf;
      end
    end
  end

  // Outputs straight from flops, except clock enable, which never drops
  assign hostWait = waitFf;
  assign hostRdData = rdDataFf;
  assign hostRdValid = rdValidFf;
  assign sdCke = rst_n || !rst_n; // see RULE8
  assign {sdRasN, sdCasN, sdWeN} = cmdFf;
  assign sdCsN = csNFf;
  assign sdBa = baFf;
  assign sdAddr = addrFf;
  assign sdDqm = dqmFf;
  assign sdBusOe = busOeFf;
  assign sdDqOut = dqOutFf;
  assign sdDqOe = dqOeFf;
  assign bridgeReq = bridgeReqFf;

  // ==========================================================
  // Checks
  localparam int RD_LAT = CAS_LAT + 4;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_cke_high: assert property (sdCke) else $error("cke dropped"); // see RULE8
  a_wait_init: assert property (!readyFf |=> hostWait) // see RULE19
    else $error("request accepted before init");
  a_rd_latency: assert property (consume && !pendWrFf |-> ##RD_LAT hostRdValid) // see RULE15
    else $error("read valid not at latency");
  a_ref_served: assert property ($rose(tmr.refDue) |-> ##[1:60] cmdFf == CMD_REF) // see RULE17
    else $error("refresh not issued");
  a_init_refs: assert property ($rose(stateFf == S_INIT_MRS) |-> // see RULE16
    initRefFf == 4'(INIT_REFS))
    else $error("wrong init refresh count");
  a_no_early_cmd: assert property (!tmr.initDone |=> cmdFf == CMD_NOP) // see RULE18
    else $error("command before settle delay");
  a_hit_column: assert property (consume |=> // see RULE11
    (cmdFf == CMD_RD || cmdFf == CMD_WR) && openFf)
    else $error("hit did not issue column command");
  a_pre_on_stop: assert property (stateFf == S_OPEN && !consume && dlyDone // see RULE13
    && wrRecFf == 2'h0 && !pendFf && !hostRead && !hostWrite |=> cmdFf == CMD_PRE)
    else $error("row not closed when traffic stopped");
  a_bridge_hold: assert property (SHARE_PINS && stateFf == S_OPEN |-> bridgeReq) // see RULE12
    else $error("bridge released with row open");

  c_read: cover property (hostRdValid ##1 hostRdValid);
  c_write: cover property (cmdFf == CMD_WR);
  c_ref_open: cover property (stateFf == S_OPEN && tmr.refDue);
endmodule

// *** hw/sdc_pkg.sv ***
// Shared constants for the SDRAM controller: timing, command codes, field positions
package sdc_pkg;
  // ==========================================================
  // Clock and printed times
  localparam int CLK_KHZ = 25000;         // Controller clock, 25 MHz
  localparam int T_INIT_NS = 100000;      // Power-up settle delay, 100 us
  localparam int T_REFI_PS = 15625000;    // Refresh interval, 15.625 us
  localparam int T_RP_NS = 20;            // Precharge period
  localparam int T_RFC_NS = 70;           // Auto-refresh period
  localparam int T_RCD_NS = 20;           // Activate to column command

  // Least time: round up, at least one cycle
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * (CLK_KHZ / 1000) + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time: round down, at least one cycle
  function automatic int cyc_max_ps(input int ps);
    longint c;
    c = (longint'(ps) * longint'(CLK_KHZ)) / 64'd1000000000;
    return (c < 1) ? 1 : int'(c);
  endfunction

  localparam int INIT_CYC = cyc_min(T_INIT_NS);
  localparam int REFI_CYC = cyc_max_ps(T_REFI_PS);
  localparam int RP_CYC = cyc_min(T_RP_NS);
  localparam int RFC_CYC = cyc_min(T_RFC_NS);
  localparam int RCD_CYC = cyc_min(T_RCD_NS);
  localparam int MRD_CYC = 2;             // Mode register set to next command
  localparam int WR_CYC = 2;              // Write recovery before precharge

  // ==========================================================
  // Commands as {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h0;

  localparam int AP_BIT = 10;             // Address bit selecting all banks
  localparam int MODE_CAS_LSB = 4;        // Latency field in the mode word
endpackage

// *** hw/sdc_tmr_if.sv ***
// Carrier between the controller core and its timer
`timescale 1ns/1ns
interface sdc_tmr_if;
  logic initDone;  // Settle delay has elapsed
  logic refDue;    // A refresh is owed
  logic refAck;    // Core issues the owed refresh this cycle
  modport timer (output initDone, output refDue, input refAck);
  modport ctrl (input initDone, input refDue, output refAck);
endinterface

// *** hw/sdc_timer.sv ***
// Power-up delay and periodic refresh timer
`timescale 1ns/1ns
module sdc_timer import sdc_pkg::*; #(
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int REFI_CYCLES = REFI_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  sdc_tmr_if.timer tmr
);
  // ==========================================================
  // Counters
  localparam int CW = $clog2(INIT_CYCLES + REFI_CYCLES + 1);
  logic [CW-1:0] initCntFf;  // Counts up to the settle delay
  logic [CW-1:0] refCntFf;   // Counts one refresh interval
  logic initDoneFf;          // Settle delay over
  logic refDueFf;            // Sticky refresh request

  // Settle delay after reset before any command
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      initCntFf <= '0;
      initDoneFf <= 1'b0;
    end else if (!initDoneFf) begin
      initCntFf <= initCntFf + CW'(1);
      initDoneFf <= (initCntFf == CW'(INIT_CYCLES - 1)); // see RULE18
    end
  end

  // Refresh interval; the timer starts once the settle delay is over
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      refCntFf <= '0;
      refDueFf <= 1'b0;
    end else if (initDoneFf) begin
      if (refCntFf == CW'(REFI_CYCLES - 1)) begin
        refCntFf <= '0;
        refDueFf <= 1'b1; // see RULE17
      end else begin
        refCntFf <= refCntFf + CW'(1);
        // A new expiry in the ack cycle wins over the clear
        if (tmr.refAck) begin
          refDueFf <= 1'b0;
        end
      end
    end
  end

  assign tmr.initDone = initDoneFf;
  assign tmr.refDue = refDueFf;
endmodule

// *** testbench/sdc_sdram_model.sv ***
// Behavioural SDRAM chip standing on the far side of the controller
`timescale 1ns/1ns
module sdc_sdram_model import sdc_pkg::*; #(
  parameter int CAS_LAT = 3  // Read latency in clocks
) (
  input wire logic clock,
  input wire logic sdCke,
  input wire logic [0:0] sdCsN,
  input wire logic sdRasN,
  input wire logic sdCasN,
  input wire logic sdWeN,
  input wire logic [1:0] sdBa,
  input wire logic [11:0] sdAddr,  // All address bits wired, none dropped
  input wire logic [3:0] sdDqm,
  input wire logic sdBusOe,
  input wire logic [31:0] sdDqOut,
  input wire logic sdDqOe,
  output logic [31:0] sdDqIn
);
  // ==========================================================
  // Storage and counters
  logic [31:0] mem [int];      // Words keyed by {bank,row,col}
  logic [11:0] openRow [4];    // Row latched by the last activate per bank
  logic rowOpen = 1'b0;        // Some row is open
  int refCount = 0;            // Refresh commands seen
  int actCount = 0;            // Activate commands seen
  int drvId = 0;               // Newest read burst owning the data lines
  int key;
  logic [2:0] cmd;
  logic [31:0] word;
  logic [31:0] drv = 32'hA5A5A5A5;  // Chip side of the data lines

  // Wire level: controller drive wins, else the chip's own pattern
  assign sdDqIn = (sdDqOe === 1'b1) ? sdDqOut : drv;

  // ==========================================================
  // Read data return
  // After its slot the line shows the inverse, so stale data never passes
  task automatic read_out(input logic [31:0] d);
    int id;
    repeat (CAS_LAT - 1) @(posedge clock);
    #1;
    drvId++;
    id = drvId;
    drv = d;
    @(posedge clock);
    #2;
    if (drvId == id) begin
      drv = ~d;
    end
  endtask

  // ==========================================================
  // Command decoder, sampled on the shared clock edge
  always @(posedge clock) begin
    // Nothing counts while the pins belong to the bridge's other users
    cmd = (sdBusOe === 1'b1 && sdCsN === 1'b0 && sdCke === 1'b1) ?
      {sdRasN, sdCasN, sdWeN} : CMD_NOP;
    key = int'({sdBa, openRow[sdBa], sdAddr[7:0]});
    word = mem.exists(key) ? mem[key] : 32'h0;
    case (cmd)
      CMD_ACT: begin
        actCount++;
        openRow[sdBa] = sdAddr;
        rowOpen = 1'b1;
      end
      CMD_PRE: rowOpen = 1'b0;
      CMD_REF: refCount++;
      CMD_WR: begin
        // Masked bytes, or data lines left undriven, keep their old contents
        for (int i = 0; i < 4; i++) begin
          if (sdDqm[i] === 1'b0 && sdDqOe === 1'b1) word[8*i +: 8] = sdDqOut[8*i +: 8];
        end
        mem[key] = word;
      end
      CMD_RD: begin
        fork
          read_out(word);
        join_none
      end
      default: ;
    endcase
  end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the SDRAM controller core
`timescale 1ns/1ns
module tb import sdc_pkg::*;;
  // ==========================================================
  // Settings and signals
  localparam int INIT_N = 20;  // Shortened settle delay
  localparam int REFI_N = 60;  // Shortened refresh interval
  localparam int CL = 2;       // Non-default latency under test
  localparam int NREF = 3;     // Non-default init refresh count
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [21:0] hostAddr = 22'h0;
  logic hostRead = 1'b0;
  logic hostWrite = 1'b0;
  logic [31:0] hostWrData = 32'h0;
  logic [3:0] hostByteEn = 4'hF;
  logic bridgeGrant = 1'b0;
  logic hostWait, hostRdValid, sdCke, sdRasN, sdCasN, sdWeN, sdBusOe, sdDqOe, bridgeReq;
  logic [0:0] sdCsN;
  logic [1:0] sdBa;
  logic [11:0] sdAddr;
  logic [3:0] sdDqm;
  logic [31:0] hostRdData, sdDqOut, sdDqIn;
  logic [31:0] rnd = 32'hD5DE9B1D;   // Stimulus stream
  logic [31:0] gRnd = 32'hD5DE9B1D;  // Grant delay stream
  logic [31:0] mem [int];            // Reference memory by word address
  logic [31:0] expQ[$];              // Read data still owed, in order
  int rdCyc[$];                      // Edges at which read commands hit the pins
  int cyc = 0;
  int err_count = 0;
  int n_checks = 0;
  int lastWait, a0, r0;

  // ==========================================================
  // Design, far-side chip and clock
  sdc_core #(.CAS_LAT(CL), .INIT_REFS(NREF), .SHARE_PINS(1'b1),
    .INIT_CYCLES(INIT_N), .REFI_CYCLES(REFI_N)) uut (.clock(clock), .rst_n(rst_n),
    .hostAddr(hostAddr), .hostRead(hostRead), .hostWrite(hostWrite), .hostWrData(hostWrData),
    .hostByteEn(hostByteEn), .hostWait(hostWait), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid), .sdCke(sdCke), .sdCsN(sdCsN), .sdRasN(sdRasN),
    .sdCasN(sdCasN), .sdWeN(sdWeN), .sdBa(sdBa), .sdAddr(sdAddr), .sdDqm(sdDqm),
    .sdBusOe(sdBusOe), .sdDqOut(sdDqOut), .sdDqOe(sdDqOe), .sdDqIn(sdDqIn),
    .bridgeReq(bridgeReq), .bridgeGrant(bridgeGrant));
  sdc_sdram_model #(.CAS_LAT(CL)) mdl (.clock(clock), .sdCke(sdCke), .sdCsN(sdCsN),
    .sdRasN(sdRasN), .sdCasN(sdCasN), .sdWeN(sdWeN), .sdBa(sdBa), .sdAddr(sdAddr),
    .sdDqm(sdDqm), .sdBusOe(sdBusOe), .sdDqOut(sdDqOut), .sdDqOe(sdDqOe), .sdDqIn(sdDqIn));
  initial begin
    forever #20 clock = ~clock;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One host request, held until the edge that takes it; the reference memory is updated there
  task automatic do_req(input logic rd, input logic [21:0] a, input logic [31:0] d,
                        input logic [3:0] be);
    int n;
    logic [31:0] w;
    n = 0;
    #1;
    hostAddr = a;
    hostRead = rd;
    hostWrite = !rd;
    hostWrData = d;
    hostByteEn = be;
    do begin
      @(posedge clock);
      n++;
    end while (hostWait !== 1'b0 && n < 400);
    if (n >= 400) check("request taken", 1'b0, 1'b1);
    lastWait = n;
    w = mem.exists(int'(a)) ? mem[int'(a)] : 32'h0;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) w[8*i +: 8] = d[8*i +: 8];
    end
    if (rd) expQ.push_back(mem.exists(int'(a)) ? mem[int'(a)] : 32'h0);
    else mem[int'(a)] = w;
  endtask

  // Drop the request and let some edges pass
  task automatic idle(input int c);
    #1;
    hostRead = 1'b0;
    hostWrite = 1'b0;
    repeat (c) @(posedge clock);
  endtask

  // ==========================================================
  // Continuous monitors
  // Arbiter grants after a random delay and keeps the grant while asked
  always @(posedge clock) begin
    #1;
    gRnd = lfsr(gRnd);
    bridgeGrant = bridgeReq && (bridgeGrant || gRnd[0]);
  end

  always @(posedge clock) begin
    cyc++;
    check("clock enable", sdCke, 1'b1);
    if (sdBusOe === 1'b1) check("bus drive granted", bridgeGrant, 1'b1);
    if (sdBusOe === 1'b1 && sdCsN === 1'b0 && {sdRasN, sdCasN, sdWeN} === CMD_RD) begin
      rdCyc.push_back(cyc);
    end
    if (hostRdValid === 1'b1) begin
      // A valid with nothing owed is itself a mismatch
      if (expQ.size() == 0 || rdCyc.size() == 0) begin
        check("spare read valid", 1'b1, 1'b0);
      end else begin
        check("read data", hostRdData, expQ.pop_front());
        check("read latency", 32'(cyc - rdCyc.pop_front()), CL + 3);
      end
    end
  end

  // Cut a hang short well beyond the expected run
  initial begin
    #(40 * 20000);
    err_count++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    check("wait in reset", hostWait, 1'b1);
    rst_n <= 1'b1;
    // A read presented at release must stall through the whole init
    do_req(1'b1, 22'h0, 32'h0, 4'hF);
    check("settle stall", lastWait >= INIT_N, 1'b1);
    check("init refreshes", mdl.refCount, NREF);
    // Same-row writes back to back, then the row must close when idle
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      do_req(1'b0, {2'd1, 12'h005, 8'(i)}, rnd, rnd[7:4]);
    end
    idle(8);
    check("row closed", mdl.rowOpen, 1'b0);
    for (int i = 0; i < 8; i++) begin
      check("stored word", mdl.mem[int'({2'd1, 12'h005, 8'(i)})],
            mem[int'({2'd1, 12'h005, 8'(i)})]);
    end
    // Same-row read stream keeps the row and the bridge; the first read still has to ask
    a0 = mdl.actCount;
    r0 = mdl.refCount;
    for (int i = 0; i < 8; i++) begin
      do_req(1'b1, {2'd1, 12'h005, 8'(i)}, 32'h0, 4'hF);
      if (i > 0) check("bridge held", bridgeReq, 1'b1);
    end
    idle(12);
    check("row hit acts", mdl.actCount - a0 <= 1 + mdl.refCount - r0, 1'b1);
    // Alternating banks pay an activate each
    a0 = mdl.actCount;
    for (int i = 0; i < 8; i++) begin
      do_req(1'b1, {1'b0, 1'(i), 12'h005, 8'(i)}, 32'h0, 4'hF);
    end
    idle(12);
    check("bank switch acts", mdl.actCount - a0 >= 8, 1'b1);
    // Random mix over a few banks, rows and columns, refresh interleaving
    for (int i = 0; i < 48; i++) begin
      rnd = lfsr(rnd);
      a0 = rnd;
      rnd = lfsr(rnd);
      do_req(a0[31], {a0[21:20], 10'h0, a0[11:10], 4'h0, a0[3:0]}, rnd, a0[7:4]);
    end
    idle(20);
    // Idle span: refreshes keep coming at the interval
    r0 = mdl.refCount;
    idle(10 * REFI_N);
    check("refresh rate", (mdl.refCount - r0 >= 9) && (mdl.refCount - r0 <= 11), 1'b1);
    check("row closed idle", mdl.rowOpen, 1'b0);
    check("reads outstanding", expQ.size(), 0);
    report_and_stop();
  end
endmodule
